// ===== src/mplc_map.svh
// constants of the multichannel phase lock controller
`ifndef MPLC_MAP_SVH
`define MPLC_MAP_SVH

// synthesis reference distributed by a direct-synthesis master, in Hz
`define MPLC_DDS_REF_HZ       27487800
// phase-locked ceiling for direct-synthesis channels, in Hz
`define MPLC_LOCK_MAX_HZ      10000000
// default ceiling for clock-synthesised channels, in Hz
`define MPLC_PLL_MAX_HZ       40000000
// phase range and full turn, in tenths of a degree
`define MPLC_PHASE_LIMIT      3600
`define MPLC_FULL_TURN        3600
// default channel count and field widths
`define MPLC_NUM_CH           4
`define MPLC_FREQ_W           32
`define MPLC_PHASE_W          13
`define MPLC_POINT_W          16

`endif

// ===== src/mplc_pkg.sv
// types of the multichannel phase lock controller
package mplc_pkg;

    typedef enum logic [1:0] {
        ROLE_FREE        = 2'h0,
        ROLE_MASTER      = 2'h1,
        ROLE_MASTER_FREQ = 2'h2,
        ROLE_SLAVE       = 2'h3
    } mplc_role_type;

    typedef enum logic [1:0] {
        LOCK_OFF = 2'h1,
        LOCK_ON  = 2'h2
    } mplc_lock_type;

    typedef enum logic [2:0] {
        ERR_NONE         = 3'h0,
        ERR_MULTI_MASTER = 3'h1,
        ERR_NO_MASTER    = 3'h2,
        ERR_MIXED_SYNTH  = 3'h3,
        ERR_FREQ_DIFFER  = 3'h4,
        ERR_NOT_CONT     = 3'h5,
        ERR_FREQ_HIGH    = 3'h6,
        ERR_FREQ_REFUSED = 3'h7
    } mplc_error_type;

endpackage : mplc_pkg

// ===== src/mplc_clock_route.sv
// per-channel sample clock routing
`timescale 1ns/10ps
module mplc_clock_route (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clockEnable,
    input  wire logic follow,
    input  wire logic ownIsPll,
    input  wire logic ownDdsTick,
    input  wire logic ownPllTick,
    input  wire logic masterIsPll,
    input  wire logic masterDdsTick,
    input  wire logic masterPllTick,
    output logic      channelTick
);
    logic ownTick;
    logic masterTick;
    logic next_channelTick;

    always_comb begin
        ownTick    = ownIsPll ? ownPllTick : ownDdsTick;
        masterTick = masterIsPll ? masterPllTick : masterDdsTick;
        next_channelTick = follow ? masterTick : ownTick;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            channelTick <= 1'b0;
        end else if (clockEnable) begin
            channelTick <= next_channelTick;
        end
    end
endmodule : mplc_clock_route

// ===== src/mplc_phase_quant.sv
// per-channel relative phase and point offset
`timescale 1ns/10ps
`include "mplc_map.svh"
module mplc_phase_quant #(
    parameter int PHASE_W = `MPLC_PHASE_W,
    parameter int POINT_W = `MPLC_POINT_W
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      clockEnable,
    input  wire logic                      active,
    input  wire logic signed [PHASE_W-1:0] ownPhase,
    input  wire logic signed [PHASE_W-1:0] masterPhase,
    input  wire logic        [POINT_W-1:0] pointCount,
    output logic signed      [PHASE_W:0]   relPhase,
    output logic signed      [POINT_W:0]   pointOffset
);
    localparam logic signed [PHASE_W:0] TURN = (PHASE_W+1)'(`MPLC_FULL_TURN);
    logic signed [PHASE_W:0] diff;
    logic signed [31:0]      product;
    logic signed [31:0]      points;

    always_comb begin
        diff = (PHASE_W+1)'(ownPhase - masterPhase);
        if (diff > TURN) begin
            diff = (PHASE_W+1)'(diff - TURN - TURN);
        end else if (diff < -TURN) begin
            diff = (PHASE_W+1)'(diff + TURN + TURN);
        end
        product = 32'(diff) * $signed({{(32-POINT_W){1'b0}}, pointCount});
        points  = product / 32'sd3600;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            relPhase    <= '0;
            pointOffset <= '0;
        end else if (clockEnable) begin
            relPhase    <= active ? diff : '0;
            pointOffset <= active ? (POINT_W+1)'(points) : '0;
        end
    end
endmodule : mplc_phase_quant

// ===== src/mplc_lock_ctrl.sv
// inter-channel frequency and phase lock controller
`timescale 1ns/10ps
`include "mplc_map.svh"

// How it works
// - slaves take the master's clock when locked
// - any channel master, any subset slaves
// - lock pulse aligns channels, reissued on change
// - synthesis master distributes its reference tick
// - clock-synthesised master distributes its sample clock
// - four roles per channel, free after reset
// - tracking master frequency copied to slaves, relock
// - plain master promoted to tracking for PLL
// - error unless exactly one master
// - error on mixed synthesis kinds
// - error when tracking and frequencies differ
// - error when a locked channel not continuous
// - error when synthesis frequency above ceiling
// - excessive frequency during lock refused, lock stays
// - positive offset advances, negative delays slave
// - relative phase is slave minus master offset
// - synthesis phase 0.1 degree, plus/minus 360
// - arbitrary phase step is turn over points
// - phase or frequency change relocks slaves
// - lock switchable, errors at enable attempt
// - arbitrary length mismatch never flagged
module mplc_lock_ctrl #(
    parameter int NUM_CH      = `MPLC_NUM_CH,
    parameter int FREQ_W      = `MPLC_FREQ_W,
    parameter int PHASE_W     = `MPLC_PHASE_W,
    parameter int POINT_W     = `MPLC_POINT_W,
    parameter int PLL_MAX_HZ  = `MPLC_PLL_MAX_HZ,
    parameter int LOCK_MAX_HZ = `MPLC_LOCK_MAX_HZ
) (
    input  wire logic                                  clock,
    input  wire logic                                  rst_n,
    input  wire logic                                  clockEnable,
    input  wire logic                                  lockOnReq,
    input  wire logic                                  lockOffReq,
    input  wire mplc_pkg::mplc_role_type [NUM_CH-1:0]  roleIn,
    input  wire logic [NUM_CH-1:0]                     roleWrite,
    input  wire logic [NUM_CH-1:0][FREQ_W-1:0]         freqIn,
    input  wire logic [NUM_CH-1:0]                     freqWrite,
    input  wire logic [NUM_CH-1:0][PHASE_W-1:0]        phaseIn,
    input  wire logic [NUM_CH-1:0]                     phaseWrite,
    input  wire logic [NUM_CH-1:0]                     synthIsPll,
    input  wire logic [NUM_CH-1:0]                     continuousMode,
    input  wire logic [NUM_CH-1:0][POINT_W-1:0]        pointCount,
    input  wire logic [NUM_CH-1:0]                     ddsRefTick,
    input  wire logic [NUM_CH-1:0]                     pllClockTick,
    output logic [NUM_CH-1:0]                          channelClockTick,
    output logic [NUM_CH-1:0]                          lockPulse,
    output logic                                       lockActive,
    output mplc_pkg::mplc_role_type [NUM_CH-1:0]       roleOut,
    output logic [NUM_CH-1:0][FREQ_W-1:0]              channelFreq,
    output logic [NUM_CH-1:0][PHASE_W:0]               relPhase,
    output logic [NUM_CH-1:0][POINT_W:0]               pointOffset,
    output mplc_pkg::mplc_error_type                   errorCode,
    output logic                                       errorStrobe
);

    localparam int IDX_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    localparam logic [FREQ_W-1:0] DDS_CEIL = FREQ_W'(LOCK_MAX_HZ);
    localparam logic [FREQ_W-1:0] PLL_CEIL = FREQ_W'(PLL_MAX_HZ);
    localparam logic signed [PHASE_W-1:0] PHASE_MAX = PHASE_W'(`MPLC_PHASE_LIMIT);

    typedef struct packed {
        mplc_pkg::mplc_lock_type                 lockState;
        mplc_pkg::mplc_role_type [NUM_CH-1:0]    role;
        logic [NUM_CH-1:0][FREQ_W-1:0]           freq;
        logic [NUM_CH-1:0][PHASE_W-1:0]          phase;
        logic [IDX_W-1:0]                        masterIdx;
        logic                                    masterPll;
        mplc_pkg::mplc_error_type                errorCode;
        logic                                    errorStrobe;
        logic [NUM_CH-1:0]                       lockPulse;
    } mplc_state_type;

    mplc_state_type state;
    mplc_state_type next_state;

    logic [NUM_CH-1:0] locked;
    logic [NUM_CH-1:0] follow;
    logic [IDX_W-1:0]  candIdx;
    logic [2:0]        masterCount;

    logic              anyDds;
    logic              anyPll;
    logic              anyNotCont;
    logic              anyTooHigh;
    logic              anyDiffer;

    logic              candTracking;
    logic              relock;
    logic              refused;
    logic              masterFreqWrite;
    logic              tracking;

    mplc_pkg::mplc_error_type checkError;

    function automatic logic [PHASE_W-1:0] clampPhase(
        input logic signed [PHASE_W-1:0] value
    );
        if (value > PHASE_MAX) begin
            return PHASE_MAX;
        end else if (value < -PHASE_MAX) begin
            return -PHASE_MAX;
        end
        return value;
    endfunction : clampPhase

    function automatic logic isMasterRole(
        input mplc_pkg::mplc_role_type role
    );
        return (role == mplc_pkg::ROLE_MASTER) || (role == mplc_pkg::ROLE_MASTER_FREQ);
    endfunction : isMasterRole

    // enable checks over the current configuration
    always_comb begin
        masterCount = 3'h0;
        candIdx     = '0;
        anyDds      = 1'b0;
        anyPll      = 1'b0;
        anyNotCont  = 1'b0;
        anyTooHigh  = 1'b0;
        anyDiffer   = 1'b0;

        for (int i = 0; i < NUM_CH; i++) begin
            if (isMasterRole(state.role[i])) begin
                if (masterCount != 3'h7) begin
                    masterCount = masterCount + 3'h1;
                end
                candIdx = IDX_W'(i);
            end
        end

        for (int i = 0; i < NUM_CH; i++) begin
            if (state.role[i] != mplc_pkg::ROLE_FREE) begin
                anyDds     = anyDds | ~synthIsPll[i];
                anyPll     = anyPll | synthIsPll[i];
                anyNotCont = anyNotCont | ~continuousMode[i];
                if (!synthIsPll[i] && state.freq[i] > DDS_CEIL) begin
                    anyTooHigh = 1'b1;
                end
                if (state.freq[i] != state.freq[candIdx]) begin
                    anyDiffer = 1'b1;
                end
            end
        end

        candTracking = (state.role[candIdx] == mplc_pkg::ROLE_MASTER_FREQ) ||
                       anyPll;

        if (masterCount > 3'h1) begin
            checkError = mplc_pkg::ERR_MULTI_MASTER;
        end else if (masterCount == 3'h0) begin
            checkError = mplc_pkg::ERR_NO_MASTER;
        end else if (anyDds && anyPll) begin
            checkError = mplc_pkg::ERR_MIXED_SYNTH;
        end else if (candTracking && anyDiffer) begin
            checkError = mplc_pkg::ERR_FREQ_DIFFER;
        end else if (anyNotCont) begin
            checkError = mplc_pkg::ERR_NOT_CONT;
        end else if (anyTooHigh) begin
            checkError = mplc_pkg::ERR_FREQ_HIGH;
        end else begin
            checkError = mplc_pkg::ERR_NONE;
        end
    end

    // state update
    always_comb begin
        next_state             = state;
        next_state.errorStrobe = 1'b0;
        next_state.lockPulse   = '0;
        relock                 = 1'b0;
        refused                = 1'b0;
        masterFreqWrite        = 1'b0;

        tracking = (state.role[state.masterIdx] ==
                    mplc_pkg::ROLE_MASTER_FREQ);

        unique case (state.lockState)
            mplc_pkg::LOCK_OFF: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (roleWrite[i]) begin
                        next_state.role[i] = roleIn[i];
                    end
                    if (freqWrite[i]) begin
                        next_state.freq[i] = freqIn[i];
                    end
                    if (phaseWrite[i]) begin
                        next_state.phase[i] = clampPhase(phaseIn[i]);
                    end
                end

                if (lockOnReq && !lockOffReq) begin
                    next_state.errorCode   = checkError;
                    next_state.errorStrobe = 1'b1;
                    if (checkError == mplc_pkg::ERR_NONE) begin
                        // commit only on a clean check
                        next_state       = state;
                        next_state.errorCode   = mplc_pkg::ERR_NONE;
                        next_state.errorStrobe = 1'b0;
                        next_state.lockPulse   = '0;
                        next_state.lockState   = mplc_pkg::LOCK_ON;
                        next_state.masterIdx   = candIdx;
                        next_state.masterPll   = anyPll;

                        if (candTracking) begin
                            next_state.role[candIdx] = mplc_pkg::ROLE_MASTER_FREQ;
                        end
                        relock = 1'b1;
                    end else begin
                        next_state       = state;
                        next_state.errorCode   = checkError;
                        next_state.errorStrobe = 1'b1;
                        next_state.lockPulse   = '0;
                    end
                end
            end

            mplc_pkg::LOCK_ON: begin
                if (lockOffReq) begin
                    next_state.lockState = mplc_pkg::LOCK_OFF;
                end else begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (phaseWrite[i]) begin
                            next_state.phase[i] = clampPhase(phaseIn[i]);
                            relock = relock | (state.role[i] != mplc_pkg::ROLE_FREE);
                        end
                        if (freqWrite[i]) begin
                            if (state.role[i] != mplc_pkg::ROLE_FREE &&
                                freqIn[i] > (synthIsPll[i] ? PLL_CEIL : DDS_CEIL)) begin
                                refused = 1'b1;
                            end else begin
                                next_state.freq[i] = freqIn[i];
                                relock = relock | (state.role[i] != mplc_pkg::ROLE_FREE);
                                if (IDX_W'(i) == state.masterIdx) begin
                                    masterFreqWrite = 1'b1;
                                end
                            end
                        end
                    end

                    if (masterFreqWrite && tracking) begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (state.role[i] == mplc_pkg::ROLE_SLAVE) begin
                                next_state.freq[i] = freqIn[state.masterIdx];
                            end
                        end
                    end

                    if (refused) begin
                        next_state.errorCode   = mplc_pkg::ERR_FREQ_REFUSED;
                        next_state.errorStrobe = 1'b1;
                    end
                end
            end
        endcase

        if (relock) begin
            for (int i = 0; i < NUM_CH; i++) begin
                next_state.lockPulse[i] = (next_state.role[i] != mplc_pkg::ROLE_FREE);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state.lockState   <= mplc_pkg::LOCK_OFF;
            state.role        <= {NUM_CH{mplc_pkg::ROLE_FREE}};
            state.freq        <= '0;
            state.phase       <= '0;
            state.masterIdx   <= '0;
            state.masterPll   <= 1'b0;
            state.errorCode   <= mplc_pkg::ERR_NONE;
            state.errorStrobe <= 1'b0;
            state.lockPulse   <= '0;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

    // per-channel clock routing and phase
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            locked[i] = (state.lockState == mplc_pkg::LOCK_ON) &&
                        (state.role[i] != mplc_pkg::ROLE_FREE);
            follow[i] = locked[i] &&
                        (state.role[i] == mplc_pkg::ROLE_SLAVE);
        end
    end

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_channel

        mplc_clock_route u_route (
            .clock         (clock),
            .rst_n         (rst_n),
            .clockEnable   (clockEnable),
            .follow        (follow[ch]),
            .ownIsPll      (synthIsPll[ch]),
            .ownDdsTick    (ddsRefTick[ch]),
            .ownPllTick    (pllClockTick[ch]),
            .masterIsPll   (state.masterPll),
            .masterDdsTick (ddsRefTick[state.masterIdx]),
            .masterPllTick (pllClockTick[state.masterIdx]),
            .channelTick   (channelClockTick[ch])
        );

        mplc_phase_quant #(
            .PHASE_W (PHASE_W),
            .POINT_W (POINT_W)
        ) u_quant (
            .clock       (clock),
            .rst_n       (rst_n),
            .clockEnable (clockEnable),
            .active      (locked[ch]),
            .ownPhase    (state.phase[ch]),
            .masterPhase (state.phase[state.masterIdx]),
            .pointCount  (pointCount[ch]),
            .relPhase    (relPhase[ch]),
            .pointOffset (pointOffset[ch])
        );

    end

    always_comb begin
        lockPulse   = state.lockPulse;
        lockActive  = (state.lockState == mplc_pkg::LOCK_ON);
        roleOut     = state.role;
        channelFreq = state.freq;
        errorCode   = state.errorCode;
        errorStrobe = state.errorStrobe;
    end
endmodule : mplc_lock_ctrl

// ===== dv/mplc_lock_ctrl_checker.sv
// assertions on the lock controller ports
`timescale 1ns/10ps
module mplc_lock_ctrl_checker #(
    parameter int NUM_CH = 4
) (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   clockEnable,
    input wire logic                   lockOnReq,
    input wire logic                   lockOffReq,
    input wire logic [NUM_CH-1:0]      synthIsPll,
    input wire logic [NUM_CH-1:0]      lockPulse,
    input wire logic                   lockActive,
    input wire logic [NUM_CH-1:0][1:0] roleOut,
    input wire logic [2:0]             errorCode,
    input wire logic                   errorStrobe
);
    logic [NUM_CH-1:0] nonFree;
    logic [NUM_CH-1:0] plainMaster;
    int                masterCount;
    wire               enReq = clockEnable && lockOnReq && !lockOffReq && !lockActive;

    always_comb begin
        masterCount = 0;
        for (int i = 0; i < NUM_CH; i++) begin
            nonFree[i] = roleOut[i] != mplc_pkg::ROLE_FREE;
            plainMaster[i] = roleOut[i] == mplc_pkg::ROLE_MASTER;
            masterCount += int'(plainMaster[i] || roleOut[i] == mplc_pkg::ROLE_MASTER_FREQ);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    enable_outcome_a: assert property (enReq |=> lockActive != errorStrobe)
        else $error("enable outcome wrong");
    master_count_a: assert property (enReq && masterCount != 1 |=> errorStrobe && !lockActive)
        else $error("master count not flagged");
    failed_enable_a: assert property (errorStrobe && !lockActive |-> $stable(roleOut) && !$past(lockActive))
        else $error("failed enable moved roles");
    lock_off_a: assert property (clockEnable && lockOffReq |=> !lockActive)
        else $error("lock stayed on");
    relock_mask_a: assert property ($rose(lockActive) |-> lockPulse == nonFree)
        else $error("bad relock mask");
    free_quiet_a: assert property ((lockPulse & ~nonFree) == '0)
        else $error("free channel pulsed");
    role_promote_a: assert property ($rose(lockActive) && ($past(synthIsPll) & nonFree) != '0 |-> plainMaster == '0)
        else $error("master not promoted");
    refused_stays_a: assert property (errorStrobe && errorCode == mplc_pkg::ERR_FREQ_REFUSED |-> lockActive && $past(lockActive))
        else $error("refusal dropped lock");
    role_reset_a: assert property ($rose(rst_n) |-> nonFree == '0 && !lockActive)
        else $error("roles not free");

    cover property ($rose(lockActive));
    cover property (errorStrobe && errorCode == mplc_pkg::ERR_FREQ_REFUSED);
    cover property (enReq && masterCount == 0);
endmodule : mplc_lock_ctrl_checker

// ===== dv/mplc_tick_source.sv
// reference and sample clock ticks offered to every channel
`timescale 1ns/10ps
module mplc_tick_source #(
    parameter int NUM_CH = 4
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    output logic [NUM_CH-1:0] ddsRefTick,
    output logic [NUM_CH-1:0] pllClockTick
);
    logic [15:0] lfsr;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lfsr <= 16'hACE1;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end
    assign ddsRefTick   = lfsr[NUM_CH-1:0];
    assign pllClockTick = lfsr[NUM_CH+7:8];
endmodule : mplc_tick_source

// ===== dv/mplc_lock_ctrl_tb.sv
// self-checking bench for the lock controller
`timescale 1ns/10ps
module mplc_lock_ctrl_tb;
    typedef struct packed {
        mplc_pkg::mplc_error_type code;
        logic [3:0]               pulse;
        logic                     active;
        logic [1:0]               idx;
        logic [31:0]              freq;
    } mplc_note_type;

    mplc_pkg::mplc_role_type [3:0] roleIn;
    mplc_pkg::mplc_role_type [3:0] roleOut;
    mplc_pkg::mplc_error_type      errorCode;

    logic             clock = 1'b0;
    logic             rst_n = 1'b0;
    logic             clockEnable = 1'b1;
    logic             lockOnReq = 1'b0;
    logic             lockOffReq = 1'b0;
    logic [3:0]       roleWrite = 4'h0;
    logic [3:0][31:0] freqIn = '0;
    logic [3:0]       freqWrite = 4'h0;
    logic [3:0][12:0] phaseIn = '0;
    logic [3:0]       phaseWrite = 4'h0;
    logic [3:0]       synthIsPll = 4'h0;
    logic [3:0]       continuousMode = 4'h0;
    logic [3:0][15:0] pointCount = '0;
    logic [3:0]       ddsRefTick;
    logic [3:0]       pllClockTick;
    logic [3:0]       channelClockTick;
    logic [3:0]       lockPulse;
    logic             lockActive;
    logic [3:0][31:0] channelFreq;
    logic [3:0][13:0] relPhase;
    logic [3:0][16:0] pointOffset;
    logic             errorStrobe;
    logic [3:0][31:0] tbFreq = '0;
    logic [31:0]      f;
    mplc_note_type    n;
    mplc_note_type    noteQ[$];
    int               fails = 0;
    int               totalChecks = 0;
    logic [7:0]  cfgRole [6] = '{8'h35, 8'h0F, 8'h3D, 8'h3E, 8'h3D, 8'h3D};
    logic [31:0] cfgF1   [6] = '{32'h3E8, 32'h3E8, 32'h3E8, 32'h7D0, 32'h3E8, 32'h989681};
    logic [3:0]  cfgPll  [6] = '{4'h8, 4'h8, 4'hA, 4'h8, 4'h8, 4'h8};
    logic [3:0]  cfgCont [6] = '{4'h7, 4'h7, 4'h7, 4'h7, 4'h3, 4'h7};

    mplc_lock_ctrl u_mplc_lock_ctrl (
        .clock, .rst_n, .clockEnable, .lockOnReq, .lockOffReq, .roleIn, .roleWrite, .freqIn,
        .freqWrite, .phaseIn, .phaseWrite, .synthIsPll, .continuousMode, .pointCount,
        .ddsRefTick, .pllClockTick, .channelClockTick, .lockPulse, .lockActive, .roleOut,
        .channelFreq, .relPhase, .pointOffset, .errorCode, .errorStrobe
    );
    mplc_tick_source u_mplc_tick_source (.clock, .rst_n, .ddsRefTick, .pllClockTick);

    always #4 clock = ~clock;

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic endOfTest();
        if (noteQ.size() != 0) fails++;
        if (fails == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : endOfTest

    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask : tick

    task automatic note(input mplc_pkg::mplc_error_type c, input logic [3:0] p,
                        input logic a, input int i);
        noteQ.push_back('{c, p, a, 2'(i), tbFreq[i]});
    endtask : note

    task automatic setCfg(input logic [7:0] r, input logic [31:0] f0, input logic [31:0] f1,
                          input logic [3:0] pll, input logic [3:0] cont);
        for (int i = 0; i < 4; i++) begin
            roleIn[i] <= mplc_pkg::mplc_role_type'(r[2*i+:2]);
            freqIn[i] <= (i == 1) ? f1 : f0;
            tbFreq[i] = (i == 1) ? f1 : f0;
        end
        synthIsPll <= pll;
        continuousMode <= cont;
        roleWrite <= 4'hF;
        freqWrite <= 4'hF;
        tick(1);
        roleWrite <= 4'h0;
        freqWrite <= 4'h0;
        tick(1);
    endtask : setCfg

    task automatic pulseReq(input logic off);
        if (off) lockOffReq <= 1'b1;
        else lockOnReq <= 1'b1;
        tick(1);
        lockOffReq <= 1'b0;
        lockOnReq <= 1'b0;
        tick(2);
    endtask : pulseReq

    task automatic wr(input logic ph, input int ch, input logic [31:0] v);
        if (ph) begin
            phaseIn[ch] <= 13'(v);
            phaseWrite[ch] <= 1'b1;
        end else begin
            freqIn[ch] <= v;
            freqWrite[ch] <= 1'b1;
        end
        tick(1);
        phaseWrite[ch] <= 1'b0;
        freqWrite[ch] <= 1'b0;
        tick(2);
    endtask : wr

    task automatic followCheck(input logic pll, input int m, input int s, input int fr);
        logic [3:0] own;
        logic       t;
        for (int k = 0; k < 8; k++) begin
            t = pll ? pllClockTick[m] : ddsRefTick[m];
            own = synthIsPll[fr] ? pllClockTick : ddsRefTick;
            tick(1);
            check(64'(channelClockTick[s]), 64'(t));
            check(64'(channelClockTick[fr]), 64'(own[fr]));
        end
    endtask : followCheck

    // one note taken per strobe or relock pulse
    always @(negedge clock) begin
        if (rst_n && (errorStrobe === 1'b1 || lockPulse !== 4'h0)) begin
            if (noteQ.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                n = noteQ.pop_front();
                check(64'({errorCode, lockPulse, lockActive}), 64'({n.code, n.pulse, n.active}));
                check(64'(channelFreq[n.idx]), 64'(n.freq));
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        endOfTest();
    end

    initial begin
        foreach (roleIn[i]) roleIn[i] = mplc_pkg::ROLE_FREE;
        void'($urandom(32'h98604883));
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        check(64'(roleOut), 64'h0);
        check(64'(lockActive), 64'h0);
        for (int i = 0; i < 6; i++) begin
            setCfg(cfgRole[i], 32'h3E8, cfgF1[i], cfgPll[i], cfgCont[i]);
            note(mplc_pkg::mplc_error_type'(3'(i + 1)), 4'h0, 1'b0, 1);
            pulseReq(1'b0);
        end
        f = 32'h3E8 + ($urandom % 32'h989000);
        pointCount <= {16'($urandom), 16'($urandom), 16'h168, 16'($urandom)};
        setCfg(8'h3D, 32'h989680, f, 4'h8, 4'h7);
        clockEnable <= 1'b0;
        lockOnReq <= 1'b1;
        tick(3);
        lockOnReq <= 1'b0;
        clockEnable <= 1'b1;
        tick(1);
        check(64'(lockActive), 64'h0);
        note(mplc_pkg::ERR_NONE, 4'h7, 1'b1, 1);
        pulseReq(1'b0);
        followCheck(1'b0, 0, 1, 3);
        note(mplc_pkg::ERR_NONE, 4'h7, 1'b1, 1);
        wr(1'b1, 1, 900);
        note(mplc_pkg::ERR_NONE, 4'h7, 1'b1, 0);
        wr(1'b1, 0, 300);
        check(64'(relPhase[1]), 64'(14'h258));
        check(64'(pointOffset[1]), 64'(17'h3C));
        note(mplc_pkg::ERR_NONE, 4'h7, 1'b1, 2);
        wr(1'b1, 2, -900);
        check(64'(relPhase[2]), 64'(14'h3B50));
        f = f >> 1;
        tbFreq[1] = f;
        note(mplc_pkg::ERR_NONE, 4'h7, 1'b1, 1);
        wr(1'b0, 1, f);
        note(mplc_pkg::ERR_FREQ_REFUSED, 4'h0, 1'b1, 1);
        wr(1'b0, 1, 32'h989681);
        pulseReq(1'b1);
        check(64'(lockActive), 64'h0);
        setCfg(8'hF4, 32'h1388, 32'h1388, 4'hF, 4'hF);
        note(mplc_pkg::ERR_NONE, 4'hE, 1'b1, 1);
        pulseReq(1'b0);
        check(64'(roleOut[1]), 64'(mplc_pkg::ROLE_MASTER_FREQ));
        followCheck(1'b1, 1, 2, 0);
        f = 32'h1388 + ($urandom % 32'h2000000);
        tbFreq[3:1] = {3{f}};
        note(mplc_pkg::ERR_NONE, 4'hE, 1'b1, 3);
        wr(1'b0, 1, f);
        check(64'(channelFreq[2]), 64'(f));
        note(mplc_pkg::ERR_FREQ_REFUSED, 4'h0, 1'b1, 2);
        wr(1'b0, 2, 32'h2625A01);
        pulseReq(1'b1);
        endOfTest();
    end
endmodule : mplc_lock_ctrl_tb

bind mplc_lock_ctrl mplc_lock_ctrl_checker #(.NUM_CH(NUM_CH)) u_mplc_lock_ctrl_checker (
    .clock, .rst_n, .clockEnable, .lockOnReq, .lockOffReq, .synthIsPll, .lockPulse,
    .lockActive, .roleOut(roleOut), .errorCode(errorCode), .errorStrobe
);
